// >>> logic/ata_timing_pkg.sv
// Constants, the cycle state type and the ns-to-cycles rounding function for the ATA transfer timing control.
// Assumes one 100 MHz core clock; all phase lengths are counted in its cycles.
package ata_timing_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // Register offsets on the plain register port
    localparam logic [7:0] CTRL_OFF = 8'hDD;
    localparam logic [7:0] UDMA_TIMING_OFF = 8'hDE;
    localparam logic [7:0] STROBE_TIMING_OFF = 8'hDF;

    // Reset values
    localparam logic [7:0] UDMA_TIMING_RESET = 8'h00;
    localparam logic [7:0] STROBE_TIMING_RESET = 8'h00;
    localparam logic CTRL_EN0_RESET = 1'b0;
    localparam logic [7:0] CTRL_FIXED_ONES = 8'h02;

    // Field positions
    localparam int MODE_MSB = 2;
    localparam int EN0_BIT = 0;
    localparam int ISP_MSB = 7;
    localparam int ISP_LSB = 6;
    localparam int RT_MSB = 5;
    localparam int RT_LSB = 4;
    localparam int DTE_BIT = 3;
    localparam int PPE_BIT = 2;
    localparam int IORDY_SAMPLING_ENABLE_BIT = 1;
    localparam int FTB_BIT = 0;

    // Ultra DMA minimum times in ns
    localparam int UDMA_M0_CT_NS = 267;
    localparam int UDMA_M0_RP_NS = 333;
    localparam int UDMA_M1_CT_NS = 167;
    localparam int UDMA_M1_RP_NS = 266;
    localparam int UDMA_M2_CT_NS = 133;
    localparam int UDMA_M2_RP_NS = 200;
    localparam int UDMA_M3_CT_NS = 100;
    localparam int UDMA_M3_RP_NS = 200;
    localparam int UDMA_M4_CT_NS = 66;
    localparam int UDMA_M4_RP_NS = 200;

    // Compatible timing phases in ns
    localparam int COMPAT8_ACT_NS = 300;
    localparam int COMPAT8_REC_NS = 300;
    localparam int COMPAT16_ACT_NS = 200;
    localparam int COMPAT16_REC_NS = 100;

    // Minimum times round up to whole cycles
    function automatic logic [7:0] min_cycles(input int ns);
        return 8'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : min_cycles

    localparam logic [7:0] UDMA_M0_CT_CYC = min_cycles(UDMA_M0_CT_NS);
    localparam logic [7:0] UDMA_M0_RP_CYC = min_cycles(UDMA_M0_RP_NS);
    localparam logic [7:0] UDMA_M1_CT_CYC = min_cycles(UDMA_M1_CT_NS);
    localparam logic [7:0] UDMA_M1_RP_CYC = min_cycles(UDMA_M1_RP_NS);
    localparam logic [7:0] UDMA_M2_CT_CYC = min_cycles(UDMA_M2_CT_NS);
    localparam logic [7:0] UDMA_M2_RP_CYC = min_cycles(UDMA_M2_RP_NS);
    localparam logic [7:0] UDMA_M3_CT_CYC = min_cycles(UDMA_M3_CT_NS);
    localparam logic [7:0] UDMA_M3_RP_CYC = min_cycles(UDMA_M3_RP_NS);
    localparam logic [7:0] UDMA_M4_CT_CYC = min_cycles(UDMA_M4_CT_NS);
    localparam logic [7:0] UDMA_M4_RP_CYC = min_cycles(UDMA_M4_RP_NS);
    localparam logic [7:0] COMPAT8_ACT_CYC = min_cycles(COMPAT8_ACT_NS);
    localparam logic [7:0] COMPAT8_REC_CYC = min_cycles(COMPAT8_REC_NS);
    localparam logic [7:0] COMPAT16_ACT_CYC = min_cycles(COMPAT16_ACT_NS);
    localparam logic [7:0] COMPAT16_REC_CYC = min_cycles(COMPAT16_REC_NS);

    // Sample point and recovery counts in clocks
    localparam logic [7:0] ISP_00_CLK = 8'h05;
    localparam logic [7:0] ISP_01_CLK = 8'h04;
    localparam logic [7:0] ISP_10_CLK = 8'h03;
    localparam logic [7:0] ISP_11_CLK = 8'h02;
    localparam logic [7:0] RT_00_CLK = 8'h04;
    localparam logic [7:0] RT_01_CLK = 8'h03;
    localparam logic [7:0] RT_10_CLK = 8'h02;
    localparam logic [7:0] RT_11_CLK = 8'h01;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_WAIT_RDY = 2'b10,
        ST_RECOVER = 2'b11
    } cycle_state_t;

endpackage : ata_timing_pkg

// >>> logic/level_sync.sv
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input is a slowly changing level such as a drive ready pin.
`timescale 1ns/1ns
module level_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } sync_state_t;

    sync_state_t sync_ff;
    sync_state_t nxt_sync;

    always_comb begin
        nxt_sync.stage1 = async_in;
        nxt_sync.stage2 = sync_ff.stage1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff.stage2;
endmodule : level_sync

// >>> logic/phase_timer.sv
// Down counter that times one strobe phase in core clocks.
// Assumes the owner loads it in the cycle before the phase begins.
`timescale 1ns/1ns
module phase_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [7:0] load_value,
    output logic last
);
    typedef struct packed {
        logic [7:0] count;
    } timer_state_t;

    timer_state_t timer_ff;
    timer_state_t nxt_timer;

    always_comb begin
        nxt_timer = timer_ff;
        if (load) begin
            nxt_timer.count = load_value;
        end else if (timer_ff.count != 8'h00) begin
            nxt_timer.count = timer_ff.count - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            timer_ff <= '0;
        end else begin
            timer_ff <= nxt_timer;
        end
    end

    // Final cycle of the phase; a zero count also ends it to avoid a hang
    assign last = (timer_ff.count <= 8'h01);
endmodule : phase_timer

// >>> logic/ata_transfer_timing_control.sv
// ATA transfer timing control: timing registers and the strobe cycle engine.
// Assumes a register master on the same clock and an async drive ready pin.
//
// Contract
// - Upper five bits of the UDMA timing register always read zero.
// - Three-bit mode field selects UDMA cycle and ready-to-pause minimums.
// - Code 000 is mode 0: cycle 267 ns, pause 333 ns.
// - Code 001 is mode 1: cycle 167 ns, pause 266 ns.
// - Code 010 is mode 2: cycle 133 ns, pause 200 ns.
// - Code 011 is mode 3: cycle 100 ns, pause 200 ns.
// - Code 100 is mode 4: cycle 66 ns, pause 200 ns.
// - Sample point field sets clocks from strobe assertion to first ready sample.
// - Sample point codes 00,01,10,11 give five, four, three, two clocks.
// - In fast PIO, sample point field sets the strobe active phase length.
// - Recovery field sets minimum clocks from last ready sample to next strobe.
// - Recovery codes 00,01,10,11 give four, three, two, one clocks.
// - In fast PIO, recovery field sets the strobe inactive phase length.
// - DMA-only bit set: fast timing for DMA data, compatible for PIO data.
// - DMA-only bit clear: both DMA and PIO data use fast timing.
// - UDMA operation applies only while the drive 0 enable bit is set.
// - Non-data ports use 8-bit compatible timing; fast timing needs bank bit.
// - With ready sampling disabled, internal ready is forced asserted.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module ata_transfer_timing_control (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic cyc_req,
    input wire logic cyc_dma,
    input wire logic cyc_data_port,
    output logic cyc_ready,
    output logic cyc_done,
    output logic cyc_fast,
    output logic cyc_udma,
    input wire logic iordy_pin,
    output logic io_strobe_n,
    output logic udma_active,
    output ata_timing_pkg::cycle_state_t cyc_phase,
    output logic [7:0] udma_cycle_min,
    output logic [7:0] udma_pause_min,
    output logic prefetch_enable
);
    import ata_timing_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic [7:0] sample_clocks(input logic [1:0] code);
        logic [7:0] clocks;
        clocks = ISP_00_CLK;
        case (code)
            2'b00: clocks = ISP_00_CLK;
            2'b01: clocks = ISP_01_CLK;
            2'b10: clocks = ISP_10_CLK;
            default: clocks = ISP_11_CLK;
        endcase
        return clocks;
    endfunction : sample_clocks

    function automatic logic [7:0] recovery_clocks(input logic [1:0] code);
        logic [7:0] clocks;
        clocks = RT_00_CLK;
        case (code)
            2'b00: clocks = RT_00_CLK;
            2'b01: clocks = RT_01_CLK;
            2'b10: clocks = RT_10_CLK;
            default: clocks = RT_11_CLK;
        endcase
        return clocks;
    endfunction : recovery_clocks

    function automatic logic [7:0] udma_cycle_clocks(input logic [2:0] mode);
        logic [7:0] clocks;
        clocks = UDMA_M0_CT_CYC;
        case (mode)
            3'b000: clocks = UDMA_M0_CT_CYC;
            3'b001: clocks = UDMA_M1_CT_CYC;
            3'b010: clocks = UDMA_M2_CT_CYC;
            3'b011: clocks = UDMA_M3_CT_CYC;
            3'b100: clocks = UDMA_M4_CT_CYC;
            default: clocks = UDMA_M0_CT_CYC;
        endcase
        return clocks;
    endfunction : udma_cycle_clocks

    function automatic logic [7:0] udma_pause_clocks(input logic [2:0] mode);
        logic [7:0] clocks;
        clocks = UDMA_M0_RP_CYC;
        case (mode)
            3'b000: clocks = UDMA_M0_RP_CYC;
            3'b001: clocks = UDMA_M1_RP_CYC;
            3'b010: clocks = UDMA_M2_RP_CYC;
            3'b011: clocks = UDMA_M3_RP_CYC;
            3'b100: clocks = UDMA_M4_RP_CYC;
            default: clocks = UDMA_M0_RP_CYC;
        endcase
        return clocks;
    endfunction : udma_pause_clocks

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        cycle_state_t phase;
        logic strobe_n;
        logic done;
        logic fast;
        logic udma;
        logic sample_io;
        logic [7:0] recovery_len;
        logic [2:0] udma_mode;
        logic [7:0] strobe_timing;
        logic udma_en;
        logic [7:0] rdata;
        logic [7:0] udma_ct;
        logic [7:0] udma_rp;
    } core_state_t;

    localparam core_state_t CORE_RESET = '{
        phase: ST_IDLE,
        strobe_n: 1'b1,
        done: 1'b0,
        fast: 1'b0,
        udma: 1'b0,
        sample_io: 1'b0,
        recovery_len: 8'h00,
        udma_mode: UDMA_TIMING_RESET[MODE_MSB:0],
        strobe_timing: STROBE_TIMING_RESET,
        udma_en: CTRL_EN0_RESET,
        rdata: 8'h00,
        udma_ct: UDMA_M0_CT_CYC,
        udma_rp: UDMA_M0_RP_CYC
    };

    core_state_t core_ff;
    core_state_t nxt_core;

    logic iordy_sync;
    logic timer_load;
    logic [7:0] timer_value;
    logic timer_last;

    ////////////////////////////////////////////////////////////////////////////////
    // Sub-blocks

    level_sync ready_sync (
        .clk(clk),
        .reset(reset),
        .async_in(iordy_pin),
        .sync_out(iordy_sync)
    );

    phase_timer strobe_timer (
        .clk(clk),
        .reset(reset),
        .load(timer_load),
        .load_value(timer_value),
        .last(timer_last)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Timing class selection for a new request

    logic fast_timing_bank;
    logic dma_only_fast_timing;
    logic iordy_sampling_enable;
    logic ready_eff;
    logic use_udma;
    logic use_fast;
    logic fast_pio;
    logic [7:0] act_len;
    logic [7:0] rec_len;

    always_comb begin
        fast_timing_bank = core_ff.strobe_timing[FTB_BIT];
        dma_only_fast_timing = core_ff.strobe_timing[DTE_BIT];
        iordy_sampling_enable = core_ff.strobe_timing[IORDY_SAMPLING_ENABLE_BIT];
        ready_eff = iordy_sampling_enable ? iordy_sync : 1'b1;
        use_udma = core_ff.udma_en && cyc_dma && cyc_data_port;
        // Fast timing only on the data port with the bank bit set
        use_fast = fast_timing_bank && cyc_data_port && (cyc_dma || !dma_only_fast_timing);
        fast_pio = use_fast && !cyc_dma;
        if (use_udma) begin
            // Strobe period split into two halves of the mode minimum
            act_len = core_ff.udma_ct - (core_ff.udma_ct >> 1);
            rec_len = core_ff.udma_ct >> 1;
        end else if (use_fast) begin
            act_len = sample_clocks(core_ff.strobe_timing[ISP_MSB:ISP_LSB]);
            rec_len = recovery_clocks(core_ff.strobe_timing[RT_MSB:RT_LSB]);
        end else if (cyc_data_port) begin
            act_len = COMPAT16_ACT_CYC;
            rec_len = COMPAT16_REC_CYC;
        end else begin
            act_len = COMPAT8_ACT_CYC;
            rec_len = COMPAT8_REC_CYC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_core = core_ff;
        nxt_core.done = 1'b0;
        nxt_core.rdata = 8'h00;
        timer_load = 1'b0;
        timer_value = 8'h00;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == UDMA_TIMING_OFF) begin
                nxt_core.udma_mode = reg_wdata[MODE_MSB:0];
            end else if (reg_addr == STROBE_TIMING_OFF) begin
                nxt_core.strobe_timing = reg_wdata;
            end else if (reg_addr == CTRL_OFF) begin
                nxt_core.udma_en = reg_wdata[EN0_BIT];
            end
        end

        // Register reads; unmapped addresses read zero
        if (reg_rd) begin
            if (reg_addr == UDMA_TIMING_OFF) begin
                nxt_core.rdata = {5'h00, core_ff.udma_mode};
            end else if (reg_addr == STROBE_TIMING_OFF) begin
                nxt_core.rdata = core_ff.strobe_timing;
            end else if (reg_addr == CTRL_OFF) begin
                nxt_core.rdata = CTRL_FIXED_ONES | {7'h00, core_ff.udma_en};
            end
        end

        // Mode minimums follow the stored mode field
        nxt_core.udma_ct = udma_cycle_clocks(core_ff.udma_mode);
        nxt_core.udma_rp = udma_pause_clocks(core_ff.udma_mode);

        // Strobe cycle engine
        case (core_ff.phase)
            ST_IDLE: begin
                if (cyc_req) begin
                    nxt_core.phase = ST_ACTIVE;
                    nxt_core.strobe_n = 1'b0;
                    nxt_core.fast = use_fast && !use_udma;
                    nxt_core.udma = use_udma;
                    // Phase lengths are latched so later writes cannot stretch this cycle
                    nxt_core.recovery_len = rec_len;
                    nxt_core.sample_io = !fast_pio && !use_udma;
                    timer_load = 1'b1;
                    timer_value = act_len;
                end
            end
            ST_ACTIVE: begin
                if (timer_last) begin
                    if (core_ff.sample_io && !ready_eff) begin
                        nxt_core.phase = ST_WAIT_RDY;
                    end else begin
                        nxt_core.phase = ST_RECOVER;
                        nxt_core.strobe_n = 1'b1;
                        timer_load = 1'b1;
                        timer_value = core_ff.recovery_len;
                    end
                end
            end
            ST_WAIT_RDY: begin
                if (ready_eff) begin
                    nxt_core.phase = ST_RECOVER;
                    nxt_core.strobe_n = 1'b1;
                    timer_load = 1'b1;
                    timer_value = core_ff.recovery_len;
                end
            end
            ST_RECOVER: begin
                if (timer_last) begin
                    nxt_core.phase = ST_IDLE;
                    nxt_core.done = 1'b1;
                end
            end
            default: begin
                nxt_core.phase = ST_IDLE;
                nxt_core.strobe_n = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (reset) begin
            core_ff <= CORE_RESET;
        end else begin
            core_ff <= nxt_core;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = core_ff.rdata;
    assign cyc_ready = (core_ff.phase == ST_IDLE);
    assign cyc_done = core_ff.done;
    assign cyc_fast = core_ff.fast;
    assign cyc_udma = core_ff.udma;
    assign io_strobe_n = core_ff.strobe_n;
    assign cyc_phase = core_ff.phase;
    assign udma_active = core_ff.udma_en;
    assign udma_cycle_min = core_ff.udma_ct;
    assign udma_pause_min = core_ff.udma_rp;
    assign prefetch_enable = core_ff.strobe_timing[PPE_BIT];

endmodule : ata_transfer_timing_control

// >>> verification/timing_chk.sv
// Assertion checker for the ATA transfer timing control, bound to its top.
// Assumes it sees only the top ports and shadows the strobe timing and control registers itself.
`timescale 1ns/1ns
module timing_chk
    import ata_timing_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic cyc_req,
    input wire logic cyc_dma,
    input wire logic cyc_data_port,
    input wire logic cyc_ready,
    input wire logic cyc_done,
    input wire logic cyc_fast,
    input wire logic cyc_udma,
    input wire logic iordy_pin,
    input wire logic io_strobe_n,
    input wire logic udma_active,
    input wire ata_timing_pkg::cycle_state_t cyc_phase,
    input wire logic [7:0] udma_cycle_min,
    input wire logic [7:0] udma_pause_min,
    input wire logic prefetch_enable
);
    import ata_timing_pkg::*;
    logic [7:0] st_ff, ea_ff, er_ff, lo_ff, hi_ff;
    logic en0_ff, samp_ff, fa_ff, ud_ff, ud, fa, take, mode_wr, mode_rd;
    assign take = cyc_req && cyc_ready;
    assign mode_wr = reg_wr && reg_addr == UDMA_TIMING_OFF;
    assign mode_rd = reg_rd && reg_addr == UDMA_TIMING_OFF;
    assign ud = en0_ff && cyc_dma && cyc_data_port;
    assign fa = !ud && st_ff[0] && cyc_data_port && (cyc_dma || !st_ff[3]);

    // {cycle, pause} minimum clocks of a mode code
    function automatic logic [15:0] udma_tab(input logic [7:0] m);
        case (m[2:0])
            3'h1: return 16'h111B;
            3'h2: return 16'h0E14;
            3'h3: return 16'h0A14;
            3'h4: return 16'h0714;
            default: return 16'h1B22;
        endcase
    endfunction : udma_tab

    ////////////////////////////////////////////////////////////////////////
    // Shadow registers and phase length counters
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= 8'h00;
            en0_ff <= 1'b0;
            ea_ff <= 8'h00;
            er_ff <= 8'h00;
            lo_ff <= 8'h00;
            hi_ff <= 8'h00;
            samp_ff <= 1'b0;
            fa_ff <= 1'b0;
            ud_ff <= 1'b0;
        end else if (take) begin
            lo_ff <= 8'h00;
            hi_ff <= 8'h00;
            ud_ff <= ud;
            fa_ff <= fa;
            samp_ff <= st_ff[1] && !ud && !(fa && !cyc_dma);
            ea_ff <= ud ? udma_cycle_min - (udma_cycle_min >> 1) : fa ?
                8'h05 - {6'h00, st_ff[7:6]} : cyc_data_port ? COMPAT16_ACT_CYC : COMPAT8_ACT_CYC;
            er_ff <= ud ? udma_cycle_min >> 1 : fa ?
                8'h04 - {6'h00, st_ff[5:4]} : cyc_data_port ? COMPAT16_REC_CYC : COMPAT8_REC_CYC;
        end else begin
            if (reg_wr && reg_addr == STROBE_TIMING_OFF) st_ff <= reg_wdata;
            if (reg_wr && reg_addr == CTRL_OFF) en0_ff <= reg_wdata[0];
            lo_ff <= lo_ff + {7'h00, !io_strobe_n};
            hi_ff <= hi_ff + {7'h00, cyc_phase == ST_RECOVER};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    rd_upper_zero_a: assert property (
        $past(mode_rd) |-> reg_rdata[7:3] == 5'h00) else $error("mode upper bits not zero");
    mode_decode_a: assert property (
        !$past(reset) && !$past(reset, 2) && $past(mode_wr, 2) |->
        {udma_cycle_min, udma_pause_min} == udma_tab($past(reg_wdata, 2)))
        else $error("mode minimums wrong");
    active_len_a: assert property (
        $rose(io_strobe_n) && !samp_ff |-> lo_ff == ea_ff) else $error("active length wrong");
    recov_len_a: assert property (
        cyc_done |-> hi_ff == er_ff) else $error("recovery length wrong");
    timing_class_a: assert property (
        take |=> cyc_fast == fa_ff && cyc_udma == ud_ff) else $error("timing class wrong");
    strobe_start_a: assert property (
        take |=> !io_strobe_n && cyc_phase == ST_ACTIVE) else $error("strobe did not start");
    cycle_ends_a: assert property (
        take |-> ##[1:300] cyc_done) else $error("strobe cycle never ended");
    udma_enable_a: assert property (
        reg_wr && reg_addr == CTRL_OFF |=> udma_active == $past(reg_wdata[0]))
        else $error("udma enable not followed");
    idle_strobe_a: assert property (
        cyc_phase == ST_IDLE |-> io_strobe_n && cyc_ready) else $error("strobe low while idle");
endmodule : timing_chk

bind ata_transfer_timing_control timing_chk u_chk (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cyc_req(cyc_req), .cyc_dma(cyc_dma),
    .cyc_data_port(cyc_data_port), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
    .cyc_fast(cyc_fast), .cyc_udma(cyc_udma), .iordy_pin(iordy_pin),
    .io_strobe_n(io_strobe_n), .udma_active(udma_active), .cyc_phase(cyc_phase),
    .udma_cycle_min(udma_cycle_min), .udma_pause_min(udma_pause_min),
    .prefetch_enable(prefetch_enable));

// >>> verification/ata_drive_model.sv
// Behavioural ATA drive: answers each strobe with ready, optionally late.
// Assumes the bench sets the stall length between strobe cycles.
`timescale 1ns/1ns
module ata_drive_model (
    input wire logic clk,
    input wire logic io_strobe_n,
    input wire logic [7:0] stall,
    output logic iordy
);
    logic [7:0] cnt_ff;
    always_ff @(posedge clk) begin
        cnt_ff <= io_strobe_n ? 8'h00 : cnt_ff + 8'h01;
    end
    // Ready held low for the stall span; the pulled-up line reads high otherwise
    assign iordy = io_strobe_n || cnt_ff >= stall;
endmodule : ata_drive_model

// >>> verification/tb_top.sv
// Self-checking bench for the ATA transfer timing control.
// Assumes the drive model answers each strobe and the checker is bound in.
`timescale 1ns/1ns
module tb_top;
    import ata_timing_pkg::*;
    logic clk, reset, reg_wr, reg_rd, cyc_req, cyc_dma, cyc_data_port;
    logic cyc_ready, cyc_done, cyc_fast, cyc_udma, iordy_pin, io_strobe_n;
    logic udma_active, prefetch_enable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, udma_cycle_min, udma_pause_min, stall;
    logic [15:0] tab;
    cycle_state_t cyc_phase;
    int err_total, n_tests, last_a;

    ata_transfer_timing_control u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cyc_req(cyc_req), .cyc_dma(cyc_dma), .cyc_data_port(cyc_data_port),
        .cyc_ready(cyc_ready), .cyc_done(cyc_done), .cyc_fast(cyc_fast),
        .cyc_udma(cyc_udma), .iordy_pin(iordy_pin), .io_strobe_n(io_strobe_n),
        .udma_active(udma_active), .cyc_phase(cyc_phase), .udma_cycle_min(udma_cycle_min),
        .udma_pause_min(udma_pause_min), .prefetch_enable(prefetch_enable));
    ata_drive_model u_drive (.clk(clk), .io_strobe_n(io_strobe_n), .stall(stall),
        .iordy(iordy_pin));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rdchk

    // Runs one strobe cycle, measures active and recovery lengths
    task automatic cyc_chk(input logic dma, dp, input logic [7:0] ea, er, input logic ef, eu);
        int a, r;
        logic f, u;
        @(posedge clk);
        cyc_dma <= dma;
        cyc_data_port <= dp;
        cyc_req <= 1'b1;
        @(posedge clk);
        cyc_req <= 1'b0;
        #1;
        f = cyc_fast;
        u = cyc_udma;
        a = 0;
        r = 0;
        while (io_strobe_n === 1'b0 && a < 400) begin
            a++;
            @(posedge clk);
            #1;
        end
        while (cyc_done !== 1'b1 && r < 400) begin
            r++;
            @(posedge clk);
            #1;
        end
        last_a = a;
        if (ea !== 8'hFF) chk(8'(a), ea);
        chk(8'(r), er);
        chk({7'h00, f}, {7'h00, ef});
        chk({7'h00, u}, {7'h00, eu});
    endtask : cyc_chk

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        rdchk(UDMA_TIMING_OFF, 8'h00);
        rdchk(STROBE_TIMING_OFF, 8'h00);
        rdchk(CTRL_OFF, 8'h02);
        chk(udma_cycle_min, 8'h1B);
        wr(UDMA_TIMING_OFF, 8'hFF);
        rdchk(UDMA_TIMING_OFF, 8'h07);
        wr(STROBE_TIMING_OFF, 8'hA5);
        rdchk(STROBE_TIMING_OFF, 8'hA5);
        chk({7'h00, prefetch_enable}, 8'h01);
        wr(8'hE0, 8'h55);
        rdchk(8'hE0, 8'h00);
        rdchk(UDMA_TIMING_OFF, 8'h07);
        $display("test regs done");
    endtask : t_regs

    task automatic t_udma;
        wr(CTRL_OFF, 8'h01);
        chk({7'h00, udma_active}, 8'h01);
        wr(STROBE_TIMING_OFF, 8'h00);
        for (int m = 0; m < 8; m++) begin
            wr(UDMA_TIMING_OFF, 8'(m));
            case (m)
                1: tab = 16'h111B;
                2: tab = 16'h0E14;
                3: tab = 16'h0A14;
                4: tab = 16'h0714;
                default: tab = 16'h1B22;
            endcase
            cyc_chk(1'b1, 1'b1, tab[15:8] - tab[15:9], tab[15:9], 1'b0, 1'b1);
            chk(udma_cycle_min, tab[15:8]);
            chk(udma_pause_min, tab[7:0]);
        end
        wr(CTRL_OFF, 8'h00);
        cyc_chk(1'b1, 1'b1, 8'h14, 8'h0A, 1'b0, 1'b0);
        $display("test udma done");
    endtask : t_udma

    task automatic t_fast;
        for (int i = 0; i < 4; i++) begin
            wr(STROBE_TIMING_OFF, {2'(i), 2'(3 - i), 4'h1});
            cyc_chk(1'b0, 1'b1, 8'(5 - i), 8'(1 + i), 1'b1, 1'b0);
            cyc_chk(1'b1, 1'b1, 8'(5 - i), 8'(1 + i), 1'b1, 1'b0);
        end
        $display("test fast done");
    endtask : t_fast

    task automatic t_dte;
        wr(STROBE_TIMING_OFF, 8'hB9);
        cyc_chk(1'b0, 1'b1, 8'h14, 8'h0A, 1'b0, 1'b0);
        cyc_chk(1'b1, 1'b1, 8'h03, 8'h01, 1'b1, 1'b0);
        cyc_chk(1'b0, 1'b0, 8'h1E, 8'h1E, 1'b0, 1'b0);
        cyc_chk(1'b1, 1'b0, 8'h1E, 8'h1E, 1'b0, 1'b0);
        $display("test dma-only done");
    endtask : t_dte

    task automatic t_iordy;
        wr(STROBE_TIMING_OFF, 8'hB3);
        cyc_chk(1'b1, 1'b1, 8'h03, 8'h01, 1'b1, 1'b0);
        stall <= 8'h0C;
        cyc_chk(1'b1, 1'b1, 8'hFF, 8'h01, 1'b1, 1'b0);
        chk({7'h00, last_a >= 12 && last_a <= 18}, 8'h01);
        wr(STROBE_TIMING_OFF, 8'hB1);
        cyc_chk(1'b1, 1'b1, 8'h03, 8'h01, 1'b1, 1'b0);
        stall <= 8'h00;
        $display("test ready sampling done");
    endtask : t_iordy

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    // Clock, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        err_total = 0;
        n_tests = 0;
        reset = 1'b1;
        {reg_wr, reg_rd, cyc_req, cyc_dma, cyc_data_port} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        stall = 8'h00;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_udma();
        t_fast();
        t_dte();
        t_iordy();
        summarize();
    end

    initial begin
        #500000;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end
endmodule : tb_top
